//--- core/seg_display_defines.svh
// Register offsets, field positions, codes and timing for the display control block.
`ifndef SEG_DISPLAY_DEFINES_SVH
`define SEG_DISPLAY_DEFINES_SVH
// Register addresses.
`define ADDR_MODE_CTRL 16'h2400
`define ADDR_SUPPLY 16'h2401
`define ADDR_BATTERY 16'h2402
`define ADDR_OVERRIDE 16'h240c
`define ADDR_CONTRAST 16'h240d
`define ADDR_MAP_BASE 16'h2410
`define ADDR_SEG_BASE 16'h2480
// Field positions.
`define BIT_ENABLE 7
`define FLD_MUX 6:4
`define BIT_ALLCOM 3
`define FLD_CLK 1:0
`define FLD_VMODE 7:6
`define BIT_BAT 7
`define BIT_ALL_ON 0
`define BIT_ALL_OFF 1
`define BIT_CLEAR 2
`define FLD_CONTRAST 4:0
`define RST_BYTE 8'h00
// Supply source codes.
`define VMODE_EXT 2'b11
`define VMODE_BOOST 2'b10
`define VMODE_DAC 2'b01
`define VMODE_NONE 2'b00
// Multiplex and bias codes.
`define MUX_4_THIRD 3'b000
`define MUX_3_THIRD 3'b001
`define MUX_2_HALF 3'b010
`define MUX_3_HALF 3'b011
`define MUX_STATIC 3'b100
`define MUX_5_THIRD 3'b101
`define MUX_6_THIRD 3'b110
// Shared pins that become commons 4 and 5.
`define PIN_COM4 27
`define PIN_COM5 26
// Base frame tick period and its cycle count at 50 MHz.
`define CLK_PERIOD_NS 20
`define FRAME_TICK_NS 20480
`define FRAME_TICK_CYC (`FRAME_TICK_NS / `CLK_PERIOD_NS)
`endif

//--- core/seg_display_pkg.sv
// Types shared by the display control modules.
package seg_display_pkg;
  typedef enum logic [1:0] {BIAS_STATIC, BIAS_HALF, BIAS_THIRD} bias_t;
  typedef logic [5:0] seg_word_t;
endpackage

//--- core/frame_tick_gen.sv
// Frame tick divider selected by the frame clock setting.
`timescale 1ns/100ps
`default_nettype none
module frame_tick_gen
  import seg_display_pkg::*;
#(
  parameter int BASE_DIV = 1024
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] frame_clock_select,
  output logic tick_q
);
  // ************************************************************
  // Divider
  // ************************************************************
  logic [15:0] cnt_q;
  logic [15:0] limit;

  initial begin
    if (BASE_DIV < 1 || BASE_DIV * 8 > 65535) begin
      $error("BASE_DIV out of range");
    end
  end

  // Slower settings double the period per step.
  assign limit = 16'(BASE_DIV << frame_clock_select) - 16'h0001;

  // Count core cycles and pulse once per period.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- core/supply_mux_decode.sv
// Decodes supply source and multiplex settings into enables and common usage.
`timescale 1ns/100ps
`default_nettype none
`include "seg_display_defines.svh"
module supply_mux_decode
  import seg_display_pkg::*;
(
  input wire logic [1:0] supply_source_select,
  input wire logic [2:0] mux_bias_select,
  input wire logic force_all_commons,
  input wire logic map_26,
  input wire logic map_27,
  output logic external_supply_flag,
  output logic contrast_dac_enable,
  output logic doubler_enable,
  output logic [2:0] com_count,
  output bias_t bias,
  output logic pin26_com,
  output logic pin27_com
);
  // Supply source decode.
  always_comb begin
    external_supply_flag = 1'b0;
    contrast_dac_enable = 1'b0;
    doubler_enable = 1'b0;
    unique case (supply_source_select)
      `VMODE_EXT: external_supply_flag = 1'b1;
      `VMODE_BOOST: begin
        contrast_dac_enable = 1'b1;
        doubler_enable = 1'b1;
      end
      `VMODE_DAC: contrast_dac_enable = 1'b1;
      `VMODE_NONE: ;
    endcase
  end

  // Multiplex and bias decode; the unused code falls back to four commons.
  always_comb begin
    com_count = 3'h4;
    bias = BIAS_THIRD;
    unique case (mux_bias_select)
      `MUX_4_THIRD: com_count = 3'h4;
      `MUX_3_THIRD: com_count = 3'h3;
      `MUX_2_HALF: begin
        com_count = 3'h2;
        bias = BIAS_HALF;
      end
      `MUX_3_HALF: begin
        com_count = 3'h3;
        bias = BIAS_HALF;
      end
      `MUX_STATIC: begin
        com_count = 3'h1;
        bias = BIAS_STATIC;
      end
      `MUX_5_THIRD: com_count = 3'h5;
      `MUX_6_THIRD: com_count = 3'h6;
      default: com_count = 3'h4;
    endcase
  end

  // Shared pins turn into commons by mode or by the force bit with map set.
  assign pin27_com = (mux_bias_select == `MUX_5_THIRD) |
                     (mux_bias_select == `MUX_6_THIRD) |
                     (force_all_commons & map_27);
  assign pin26_com = (mux_bias_select == `MUX_6_THIRD) |
                     (force_all_commons & map_26);
endmodule
`default_nettype wire

//--- core/segment_display_control.sv
// Segment display control: registers, supply decode, commons and segment drive.
`timescale 1ns/100ps
`default_nettype none
`include "seg_display_defines.svh"
module segment_display_control
  import seg_display_pkg::*;
#(
  parameter int NUM_SEG = 56,
  parameter int NUM_COM = 6,
  parameter int TICK_DIV = `FRAME_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic battery_mode,
  output logic [7:0] reg_rdata_q,
  output logic ext_supply_q,
  output logic dac_enable_q,
  output logic doubler_q,
  output logic battery_source_q,
  output logic [4:0] dac_level_q,
  output logic bias_ground_q,
  output bias_t bias_q,
  output logic [2:0] com_count_q,
  output logic [NUM_COM-1:0] com_drive_q,
  output logic [NUM_COM-1:0] com_idle_q,
  output logic [NUM_COM-1:0] com_ground_q,
  output logic pin26_com_q,
  output logic pin27_com_q,
  output logic [NUM_SEG-1:0] seg_on_q,
  output logic [NUM_SEG-1:0] seg_ground_q
);
  // ************************************************************
  // Configuration registers
  // ************************************************************
  localparam int MAP_BYTES = (NUM_SEG + 7) / 8;

  logic enable_q;
  logic [2:0] mux_q;
  logic allcom_q;
  logic [1:0] clk_sel_q;
  logic [1:0] vmode_q;
  logic bat_force_q;
  logic all_on_q;
  logic all_off_q;
  logic clear_q;
  logic [4:0] contrast_q;
  logic [MAP_BYTES*8-1:0] map_q;
  seg_word_t seg_data_q [NUM_SEG];
  logic [2:0] phase_q;
  logic tick;

  initial begin
    if (NUM_SEG < 28 || NUM_SEG > 64 || NUM_COM != 6) begin
      $error("Unsupported segment or common count");
    end
  end

  // Mode control byte.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
      mux_q <= 3'h0;
      allcom_q <= 1'b0;
      clk_sel_q <= 2'h0;
    end else if (reg_wr && reg_addr == `ADDR_MODE_CTRL) begin
      enable_q <= reg_wdata[`BIT_ENABLE];
      mux_q <= reg_wdata[`FLD_MUX];
      allcom_q <= reg_wdata[`BIT_ALLCOM];
      clk_sel_q <= reg_wdata[`FLD_CLK];
    end
  end

  // Supply and battery select bytes.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vmode_q <= 2'h0;
      bat_force_q <= 1'b0;
    end else if (reg_wr && reg_addr == `ADDR_SUPPLY) begin
      vmode_q <= reg_wdata[`FLD_VMODE];
    end else if (reg_wr && reg_addr == `ADDR_BATTERY) begin
      bat_force_q <= reg_wdata[`BIT_BAT];
    end
  end

  // Global override and contrast bytes.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      all_on_q <= 1'b0;
      all_off_q <= 1'b0;
      clear_q <= 1'b0;
      contrast_q <= 5'h00;
    end else if (reg_wr && reg_addr == `ADDR_OVERRIDE) begin
      all_on_q <= reg_wdata[`BIT_ALL_ON];
      all_off_q <= reg_wdata[`BIT_ALL_OFF];
      clear_q <= reg_wdata[`BIT_CLEAR];
    end else if (reg_wr && reg_addr == `ADDR_CONTRAST) begin
      contrast_q <= reg_wdata[`FLD_CONTRAST];
    end
  end

  // ************************************************************
  // Per-segment map, data and drive
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < MAP_BYTES; gi++) begin : g_map
      // One byte of the pin display map.
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          map_q[gi*8 +: 8] <= `RST_BYTE;
        end else if (reg_wr && reg_addr == `ADDR_MAP_BASE + 16'(gi)) begin
          map_q[gi*8 +: 8] <= reg_wdata;
        end
      end
    end
    for (gi = 0; gi < NUM_SEG; gi++) begin : g_seg
      logic as_com;
      assign as_com = (gi == `PIN_COM4 && pin27_com_q) ||
                      (gi == `PIN_COM5 && pin26_com_q);
      // Segment data; clear wins over a write and spares unmapped pins.
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          seg_data_q[gi] <= 6'h00;
        end else if (clear_q && map_q[gi]) begin
          seg_data_q[gi] <= 6'h00;
        end else if (reg_wr && reg_addr == `ADDR_SEG_BASE + 16'(gi)) begin
          seg_data_q[gi] <= reg_wdata[5:0];
        end
      end
      // Segment drive for the active common; overrides leave data alone.
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          seg_on_q[gi] <= 1'b0;
          seg_ground_q[gi] <= 1'b0;
        end else begin
          seg_ground_q[gi] <= !enable_q && map_q[gi];
          if (as_com) begin
            seg_on_q[gi] <= 1'b0;
          end else if (all_on_q) begin
            seg_on_q[gi] <= 1'b1;
          end else if (all_off_q) begin
            seg_on_q[gi] <= 1'b0;
          end else begin
            seg_on_q[gi] <= seg_data_q[gi][phase_q];
          end
        end
      end
    end
    for (gi = 0; gi < NUM_COM; gi++) begin : g_com
      logic avail;
      logic map_ok;
      assign avail = (gi < 4) || (gi == 4 && pin27_com_q) ||
                     (gi == 5 && pin26_com_q);
      assign map_ok = (gi < 4) || (gi == 4 && map_q[`PIN_COM4]) ||
                      (gi == 5 && map_q[`PIN_COM5]);
      // Common drive; commons beyond the mode idle at segment-off level.
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          com_drive_q[gi] <= 1'b0;
          com_idle_q[gi] <= 1'b0;
          com_ground_q[gi] <= 1'b0;
        end else begin
          com_drive_q[gi] <= enable_q && avail && phase_q == 3'(gi);
          com_idle_q[gi] <= enable_q && avail && 3'(gi) >= com_count_q;
          com_ground_q[gi] <= !enable_q && avail && map_ok;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Decode, frame timing and supply outputs
  // ************************************************************
  logic ext_d;
  logic dac_en_d;
  logic dbl_d;
  logic [2:0] com_count_d;
  bias_t bias_d;
  logic p26_d;
  logic p27_d;

  supply_mux_decode u_decode (
    .supply_source_select(vmode_q),
    .mux_bias_select(mux_q),
    .force_all_commons(allcom_q),
    .map_26(map_q[`PIN_COM5]),
    .map_27(map_q[`PIN_COM4]),
    .external_supply_flag(ext_d),
    .contrast_dac_enable(dac_en_d),
    .doubler_enable(dbl_d),
    .com_count(com_count_d),
    .bias(bias_d),
    .pin26_com(p26_d),
    .pin27_com(p27_d)
  );

  frame_tick_gen #(.BASE_DIV(TICK_DIV)) u_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .frame_clock_select(clk_sel_q),
    .tick_q(tick)
  );

  // Registered decode results and supply routing.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_supply_q <= 1'b0;
      dac_enable_q <= 1'b0;
      doubler_q <= 1'b0;
      battery_source_q <= 1'b0;
      dac_level_q <= 5'h00;
      bias_ground_q <= 1'b1;
      bias_q <= BIAS_THIRD;
      com_count_q <= 3'h4;
      pin26_com_q <= 1'b0;
      pin27_com_q <= 1'b0;
    end else begin
      ext_supply_q <= ext_d;
      dac_enable_q <= dac_en_d;
      doubler_q <= dbl_d;
      battery_source_q <= bat_force_q || battery_mode;
      dac_level_q <= ext_d ? 5'h00 : contrast_q;
      bias_ground_q <= !enable_q;
      bias_q <= bias_d;
      com_count_q <= com_count_d;
      pin26_com_q <= p26_d;
      pin27_com_q <= p27_d;
    end
  end

  // Common phase steps once per frame tick and wraps at the common count.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 3'h0;
    end else if (phase_q >= com_count_q) begin
      phase_q <= 3'h0;
    end else if (tick) begin
      phase_q <= (phase_q + 3'h1 >= com_count_q) ? 3'h0 : phase_q + 3'h1;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  logic [7:0] rd_d;
  logic [15:0] seg_off;
  logic [15:0] map_off;
  assign seg_off = reg_addr - `ADDR_SEG_BASE;
  assign map_off = reg_addr - `ADDR_MAP_BASE;

  // Read mux; unmapped addresses return zero.
  always_comb begin
    rd_d = 8'h00;
    if (reg_addr == `ADDR_MODE_CTRL) begin
      rd_d = {enable_q, mux_q, allcom_q, 1'b0, clk_sel_q};
    end else if (reg_addr == `ADDR_SUPPLY) begin
      rd_d = {vmode_q, 6'h00};
    end else if (reg_addr == `ADDR_BATTERY) begin
      rd_d = {bat_force_q, 7'h00};
    end else if (reg_addr == `ADDR_OVERRIDE) begin
      rd_d = {5'h00, clear_q, all_off_q, all_on_q};
    end else if (reg_addr == `ADDR_CONTRAST) begin
      rd_d = {3'h0, contrast_q};
    end else if (reg_addr >= `ADDR_MAP_BASE && map_off < 16'(MAP_BYTES)) begin
      rd_d = map_q[map_off[2:0]*8 +: 8];
    end else if (reg_addr >= `ADDR_SEG_BASE && seg_off < 16'(NUM_SEG)) begin
      rd_d = {2'h0, seg_data_q[seg_off[5:0]]};
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_d : 8'h00;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_ext_decode;
    @(posedge core_clk) disable iff (!rst_b)
    vmode_q == `VMODE_EXT |=> ext_supply_q && !dac_enable_q && !doubler_q;
  endproperty
  a_ext_decode: assert property (p_ext_decode)
    else $error("external supply decode wrong");

  property p_ext_ignores_dac;
    @(posedge core_clk) disable iff (!rst_b)
    ext_supply_q |-> dac_level_q == 5'h00;
  endproperty
  a_ext_ignores_dac: assert property (p_ext_ignores_dac)
    else $error("contrast used under external supply");

  property p_bat_force;
    @(posedge core_clk) disable iff (!rst_b)
    bat_force_q |=> battery_source_q;
  endproperty
  a_bat_force: assert property (p_bat_force)
    else $error("battery force not applied");

  property p_doubler;
    @(posedge core_clk) disable iff (!rst_b)
    vmode_q == `VMODE_BOOST |=> doubler_q && dac_enable_q;
  endproperty
  a_doubler: assert property (p_doubler)
    else $error("doubler not running");

  property p_contrast;
    @(posedge core_clk) disable iff (!rst_b)
    reg_wr && reg_addr == `ADDR_CONTRAST |=> contrast_q == $past(reg_wdata[4:0]);
  endproperty
  a_contrast: assert property (p_contrast)
    else $error("contrast code not stored");

  property p_six_com;
    @(posedge core_clk) disable iff (!rst_b)
    mux_q == `MUX_6_THIRD |=> com_count_q == 3'h6 && pin26_com_q && pin27_com_q;
  endproperty
  a_six_com: assert property (p_six_com)
    else $error("six common mode decode wrong");

  property p_five_com;
    @(posedge core_clk) disable iff (!rst_b)
    mux_q == `MUX_5_THIRD |=> pin27_com_q && bias_q == BIAS_THIRD;
  endproperty
  a_five_com: assert property (p_five_com)
    else $error("pin 27 not a common");

  property p_allcom_map;
    @(posedge core_clk) disable iff (!rst_b)
    allcom_q && mux_q != `MUX_6_THIRD |=> pin26_com_q == $past(map_q[`PIN_COM5]);
  endproperty
  a_allcom_map: assert property (p_allcom_map)
    else $error("force commons ignores map");

  property p_disable_ground;
    @(posedge core_clk) disable iff (!rst_b)
    !enable_q |=> bias_ground_q && seg_ground_q == $past(map_q[NUM_SEG-1:0]);
  endproperty
  a_disable_ground: assert property (p_disable_ground)
    else $error("disabled outputs not grounded");

  property p_on_wins;
    @(posedge core_clk) disable iff (!rst_b)
    all_on_q && all_off_q |=> seg_on_q[0] && seg_on_q[NUM_SEG-1];
  endproperty
  a_on_wins: assert property (p_on_wins)
    else $error("all-on lost to all-off");

  property p_off;
    @(posedge core_clk) disable iff (!rst_b)
    all_off_q && !all_on_q |=> seg_on_q == '0;
  endproperty
  a_off: assert property (p_off)
    else $error("blank left segments on");

  property p_clear;
    @(posedge core_clk) disable iff (!rst_b)
    clear_q && map_q[0] |=> seg_data_q[0] == 6'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left data");

  c_six_com: cover property (@(posedge core_clk) disable iff (!rst_b)
    mux_q == `MUX_6_THIRD && tick);
  c_both_on: cover property (@(posedge core_clk) disable iff (!rst_b)
    all_on_q && all_off_q);
  c_ext: cover property (@(posedge core_clk) disable iff (!rst_b) ext_supply_q);
endmodule
`default_nettype wire

//--- verif/display_glass.sv
// Passive segment display glass model that shows which pixels are lit.
`timescale 1ns/100ps
`default_nettype none
module display_glass #(
  parameter int NUM_SEG = 56,
  parameter int NUM_COM = 6
) (
  input wire logic core_clk,
  input wire logic [NUM_COM-1:0] com_drive_q,
  input wire logic [NUM_SEG-1:0] seg_on_q,
  output logic [NUM_SEG-1:0] lit
);
  // A pixel lights only while some common plane is driven; the glass never drives back.
  always_ff @(posedge core_clk) begin
    lit <= (|com_drive_q) ? seg_on_q : '0;
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the segment display control block.
`timescale 1ns/100ps
`default_nettype none
`include "seg_display_defines.svh"
module tb_top;
  import seg_display_pkg::*;
  localparam logic [2:0] CNT [8] = '{3'd4, 3'd3, 3'd2, 3'd3, 3'd1, 3'd5, 3'd6, 3'd4};
  localparam bias_t BIA [8] = '{BIAS_THIRD, BIAS_THIRD, BIAS_HALF, BIAS_HALF, BIAS_STATIC,
    BIAS_THIRD, BIAS_THIRD, BIAS_THIRD};
  logic core_clk, rst_b, reg_wr, reg_rd, battery_mode, rd_seen;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q;
  logic ext_supply_q, dac_enable_q, doubler_q, battery_source_q, bias_ground_q;
  logic [4:0] dac_level_q, r;
  bias_t bias_q;
  logic [2:0] com_count_q, av;
  logic [5:0] com_drive_q, com_idle_q, com_ground_q;
  logic pin26_com_q, pin27_com_q;
  logic [55:0] seg_on_q, seg_ground_q, lit;
  logic [7:0] rd_exp[$];
  logic [31:0] lfsr;
  int bad_count, samples_checked;
  segment_display_control #(.TICK_DIV(4)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .battery_mode(battery_mode), .reg_rdata_q(reg_rdata_q), .ext_supply_q(ext_supply_q),
    .dac_enable_q(dac_enable_q), .doubler_q(doubler_q), .battery_source_q(battery_source_q),
    .dac_level_q(dac_level_q), .bias_ground_q(bias_ground_q), .bias_q(bias_q),
    .com_count_q(com_count_q), .com_drive_q(com_drive_q), .com_idle_q(com_idle_q),
    .com_ground_q(com_ground_q), .pin26_com_q(pin26_com_q), .pin27_com_q(pin27_com_q),
    .seg_on_q(seg_on_q), .seg_ground_q(seg_ground_q));
  display_glass glass (.core_clk(core_clk), .com_drive_q(com_drive_q), .seg_on_q(seg_on_q),
    .lit(lit));
  // ****************************************
  // Shared tasks
  // ****************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Compares one observed value with its expectation.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Steps the pseudo-random generator.
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One-cycle write, then one idle cycle so the strobe is never set twice at one edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  // Wait that lets a register write reach the derived outputs.
  task automatic wrs(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    tick(2);
  endtask
  // One-cycle read; the expected byte is queued for the monitor.
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_exp.push_back(e);
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask
  // Counts cycles between two phase steps of the commons.
  task automatic period(input int exp);
    logic [5:0] c;
    int n;
    for (int k = 0; k < 2; k++) begin
      c = com_drive_q;
      n = 0;
      while (com_drive_q === c && n < 200) begin
        tick(1);
        n++;
      end
      // A common plane that never steps is a hang, so the run closes here.
      if (n >= 200) begin
        bad_count++;
        summarize();
      end
    end
    chk(n, exp);
  endtask
  // ****************************************
  // Read data monitor
  // ****************************************
  // Read data stands only in the cycle after the strobe, so it is sampled at that edge.
  always @(posedge core_clk) begin
    if (rd_seen && rd_exp.size() > 0) begin
      chk(reg_rdata_q, rd_exp.pop_front());
    end else if (!rd_seen && rst_b) begin
      chk(reg_rdata_q, 8'h00);
    end
    rd_seen <= reg_rd;
  end
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    battery_mode = 1'b0;
    rd_seen = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    lfsr = 32'he223;
    tick(16);
    rst_b <= 1'b1;
    tick(1);
    // Reset values, an unmapped place and the grounded disabled display.
    rd(`ADDR_MODE_CTRL, 8'h00);
    rd(`ADDR_SUPPLY, 8'h00);
    rd(`ADDR_BATTERY, 8'h00);
    rd(`ADDR_OVERRIDE, 8'h00);
    rd(`ADDR_CONTRAST, 8'h00);
    rd(16'h2408, 8'h00);
    for (int i = 0; i < 7; i++) wr(`ADDR_MAP_BASE + 16'(i), 8'hff);
    tick(2);
    chk({bias_ground_q, seg_ground_q, com_ground_q}, {1'b1, {56{1'b1}}, 6'h0f});
    // Supply codes with the power mode moved under them.
    for (int v = 0; v < 4; v++) begin
      battery_mode <= v[1];
      wrs(`ADDR_SUPPLY, {v[1:0], 6'h00});
      chk({ext_supply_q, dac_enable_q, doubler_q}, v == 3 ? 3'b100 : {1'b0, v[1] | v[0], v == 2});
      chk(battery_source_q, v[1]);
    end
    lfsr = next_rand(lfsr);
    r = {1'b1, lfsr[3:0]};
    wrs(`ADDR_CONTRAST, {3'h7, r});
    chk(dac_level_q, 5'h00);
    rd(`ADDR_CONTRAST, {3'h0, r});
    battery_mode <= 1'b0;
    wrs(`ADDR_SUPPLY, 8'h40);
    chk(dac_level_q, r);
    wrs(`ADDR_BATTERY, 8'h80);
    chk({battery_source_q, dac_enable_q}, 2'b11);
    rd(`ADDR_BATTERY, 8'h80);
    // Mux codes with pins 26 and 27 mapped away from the display.
    wr(`ADDR_MAP_BASE + 16'h0003, 8'hf3);
    for (int m = 0; m < 8; m++) begin
      wrs(`ADDR_MODE_CTRL, {1'b1, m[2:0], 4'h0});
      av = CNT[m] > 3'd4 ? CNT[m] : 3'd4;
      chk({com_count_q, bias_q}, {CNT[m], BIA[m]});
      chk({pin26_com_q, pin27_com_q}, {m == 6, m == 5 || m == 6});
      chk(com_idle_q, 6'(((1 << av) - 1) & ~((1 << CNT[m]) - 1)));
    end
    chk({bias_ground_q, seg_ground_q}, 57'h0);
    // Forcing commons honours the map bits of the two shared pins.
    wrs(`ADDR_MODE_CTRL, 8'h88);
    chk({pin26_com_q, pin27_com_q}, 2'b00);
    wrs(`ADDR_MAP_BASE + 16'h0003, 8'hff);
    chk({pin26_com_q, pin27_com_q}, 2'b11);
    wr(`ADDR_MODE_CTRL, 8'hff);
    rd(`ADDR_MODE_CTRL, 8'hfb);
    wrs(`ADDR_MODE_CTRL, 8'h80);
    // Overrides leave stored data alone; all-on wins when both are set.
    wr(`ADDR_SEG_BASE, 8'hff);
    rd(`ADDR_SEG_BASE, 8'h3f);
    for (int k = 1; k < 4; k++) begin
      wrs(`ADDR_OVERRIDE, 8'(k));
      chk(seg_on_q, k == 2 ? 56'h0 : {56{1'b1}});
    end
    chk(lit, {56{1'b1}});
    rd(`ADDR_SEG_BASE, 8'h3f);
    // Clear zeroes data and keeps beating later writes while it is set.
    wrs(`ADDR_OVERRIDE, 8'h04);
    rd(`ADDR_SEG_BASE, 8'h00);
    lfsr = next_rand(lfsr);
    wr(`ADDR_SEG_BASE + 16'h0005, lfsr[7:0]);
    rd(`ADDR_SEG_BASE + 16'h0005, 8'h00);
    wr(`ADDR_OVERRIDE, 8'h00);
    wr(`ADDR_SEG_BASE + 16'h0005, lfsr[7:0]);
    rd(`ADDR_SEG_BASE + 16'h0005, {2'b00, lfsr[5:0]});
    // Frame period follows the frame clock select field.
    for (int s = 0; s < 4; s++) begin
      wrs(`ADDR_MODE_CTRL, {6'h20, s[1:0]});
      period(4 << s);
    end
    tick(4);
    summarize();
  end
endmodule
`default_nettype wire
